/* File: core/cdr_router.sv */
`timescale 1ns/1ps
// What this block does
// - invalid graphics read goes to address zero and sets the error flag
// - invalid graphics write goes to zero with lanes off, sets the flag
// - graphics cycles to dram never snoop the processor bus
// - frame-based transfers are disconnected at each 4 KB boundary
// - graphics requests split into aligned 32-byte blocks, each checked
// - vga io is 3b0h-3bbh or 3c0h-3dfh on bits 9..0
// - vga routing on sends vga memory and io to the graphics port
// - vga routing on sends 3bch-3bfh to the hub
// - vga routing off: 3bch-3bfh to graphics only in window without legacy enable
// - vga routing off: vga ranges go to hub unless a window claims them
// - vga routing off: any io touching mono locations goes to the hub
// - vga routing on, mono clear: only 3bfh to hub; mono set: all mono to hub
// - up to four outstanding host requests, handled in arrival order
// - interrupt acknowledge to hub; deferred reply is ours only
// - branch trace message terminates without capturing data
// - io read and write go to hub or graphics port by range, except own config locations
// - memory reads route to dram, graphics port or hub by address
// - writeback write always to dram; retryable write by address
module cdr_router (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  // configuration
  input wire cdr_pkg::cdr_cfg_t I_CFG,
  // host requests
  input wire logic I_HOST_VALID,
  input wire cdr_pkg::cdr_host_req_t I_HOST_REQ,
  input wire logic I_HOST_POP,
  output logic O_HOST_READY,
  output logic O_HOST_RSP_VALID,
  output cdr_pkg::cdr_host_rsp_t O_HOST_RSP,
  // graphics requests
  input wire logic I_GFX_VALID,
  input wire logic [31:0] I_GFX_ADDR,
  input wire logic [8:0] I_GFX_BYTES,
  input wire logic I_GFX_WRITE,
  input wire logic I_GFX_FRAME_ADDR_VALID,
  input wire logic [31:0] I_GFX_FRAME_ADDR,
  input wire logic I_FLAG_CLEAR,
  output logic O_GFX_BUSY,
  output logic O_GFX_BLK_VALID,
  output cdr_pkg::cdr_gfx_blk_t O_GFX_BLK,
  output logic O_GFX_DISCONNECT,
  output logic O_INVALID_GRAPHICS_ACCESS_FLAG
);

  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta_r;
  logic rst_n_r;

  // async assert, synchronous release
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ****************************************
  // request decode
  // ****************************************
  logic [4:0] code_a;
  logic [4:0] code_b;
  logic [31:0] addr;
  logic [9:0] io_lo;
  logic [9:0] io_hi;
  logic [15:0] io_full;
  logic [3:0] io_span;
  logic is_io;
  logic is_mem_rd;
  logic is_mem_wr_wb;
  logic is_mem_wr_rt;
  logic is_inta;
  logic is_btm;
  logic is_defer;

  assign code_a = I_HOST_REQ.code_a;
  assign code_b = I_HOST_REQ.code_b;
  assign addr = I_HOST_REQ.addr;
  assign io_full = addr[15:0];
  // io span covers up to 3 bytes past the base, for touch checks
  assign io_lo = addr[9:0];
  assign io_span = 4'h3;
  assign io_hi = io_lo + {6'h00, io_span};

  assign is_io = code_a == cdr_pkg::REQA_IO_READ || code_a == cdr_pkg::REQA_IO_WRITE;
  assign is_mem_rd = code_a == cdr_pkg::REQA_MEM_RD_INV || code_a == cdr_pkg::REQA_MEM_CODE_RD
    || code_a == cdr_pkg::REQA_MEM_DATA_RD;
  assign is_mem_wr_wb = code_a == cdr_pkg::REQA_MEM_WR_WB;
  assign is_mem_wr_rt = code_a == cdr_pkg::REQA_MEM_WR_RETRY;
  assign is_inta = code_a == cdr_pkg::REQA_INTA_SPEC && code_b == cdr_pkg::REQB_ZERO;
  assign is_btm = code_a == cdr_pkg::REQA_BRANCH_TRACE && code_b == cdr_pkg::REQB_ZERO;
  assign is_defer = code_a == cdr_pkg::REQA_DEFER_REPLY;

  // ****************************************
  // legacy range classification
  // ****************************************
  logic [3:0] lane_hit;
  logic io_vga;
  logic io_port;
  logic io_mono_any;
  logic io_mono_only;
  logic io_in_window;
  logic io_cfg;
  logic mem_vga;
  logic mem_mono;
  logic mem_in_window;
  logic [9:0] lane_addr [4];

  // per-byte mono touch, aliases matched through bits 9..0
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign lane_addr[g] = io_lo + 10'(g);
      assign lane_hit[g] = !I_HOST_REQ.be_n[g] && (lane_addr[g] == 10'h3b4 || lane_addr[g] == 10'h3b5
        || lane_addr[g] == 10'h3b8 || lane_addr[g] == 10'h3b9 || lane_addr[g] == 10'h3ba
        || lane_addr[g] == cdr_pkg::MONO_ONLY_IO);
    end
  endgenerate

  assign io_vga = (io_lo >= cdr_pkg::VGA_IO_A_LO && io_lo <= cdr_pkg::VGA_IO_A_HI)
    || (io_lo >= cdr_pkg::VGA_IO_B_LO && io_lo <= cdr_pkg::VGA_IO_B_HI);
  assign io_port = io_lo >= cdr_pkg::PORT_IO_LO && io_lo <= cdr_pkg::PORT_IO_HI;
  assign io_mono_any = |lane_hit;
  assign io_mono_only = lane_hit[0] && io_lo == cdr_pkg::MONO_ONLY_IO
    || (io_lo <= cdr_pkg::MONO_ONLY_IO && io_hi >= cdr_pkg::MONO_ONLY_IO
    && lane_hit[2'(cdr_pkg::MONO_ONLY_IO - io_lo)]);
  assign io_in_window = io_full >= I_CFG.io_window_low && io_full <= I_CFG.io_window_high;
  assign io_cfg = io_full >= cdr_pkg::CFG_IO_LO && io_full <= cdr_pkg::CFG_IO_HI;
  assign mem_vga = addr >= cdr_pkg::VGA_MEM_LO && addr <= cdr_pkg::VGA_MEM_HI;
  assign mem_mono = addr >= cdr_pkg::MONO_MEM_LO && addr <= cdr_pkg::MONO_MEM_HI;
  assign mem_in_window = (addr >= I_CFG.mem_window_low && addr <= I_CFG.mem_window_high)
    || (addr >= I_CFG.prefetch_window_low && addr <= I_CFG.prefetch_window_high);

  // ****************************************
  // destination selection
  // ****************************************
  logic io_to_gfx;
  logic mem_to_gfx;
  logic mem_to_dram;
  cdr_pkg::cdr_dest_t dest;

  // io: mono wins, then vga routing, then windows
  assign io_to_gfx = (io_mono_any && I_CFG.mono_present) ? 1'b0
    : (I_CFG.vga_route && io_mono_only) ? 1'b0
    : (I_CFG.vga_route && io_port) ? 1'b0
    : (!I_CFG.vga_route && io_mono_any) ? 1'b0
    : (I_CFG.vga_route && io_vga) ? 1'b1
    : (io_in_window && !I_CFG.legacy_bus_en);

  // memory: legacy ranges first, windows, then dram
  assign mem_to_gfx = (mem_mono && I_CFG.mono_present) ? 1'b0
    : (mem_vga && I_CFG.vga_route) ? 1'b1
    : mem_vga ? mem_in_window
    : mem_in_window;
  assign mem_to_dram = !mem_vga && !mem_to_gfx && addr < I_CFG.dram_top;

  always_comb begin
    if (is_mem_wr_wb) begin
      dest = cdr_pkg::DST_DRAM;
    end else if (is_mem_rd || is_mem_wr_rt) begin
      dest = mem_to_gfx ? cdr_pkg::DST_GFX : mem_to_dram ? cdr_pkg::DST_DRAM
        : cdr_pkg::DST_HUB;
    end else if (is_io) begin
      dest = io_cfg ? cdr_pkg::DST_INTERNAL : io_to_gfx ? cdr_pkg::DST_GFX
        : cdr_pkg::DST_HUB;
    end else if (is_inta) begin
      dest = cdr_pkg::DST_HUB;
    end else if (is_btm) begin
      dest = cdr_pkg::DST_DROP;
    end else begin
      dest = cdr_pkg::DST_NONE;
    end
  end

  // ****************************************
  // in-order queue
  // ****************************************
  cdr_pkg::cdr_host_rsp_t ioq_r [cdr_pkg::IOQ_DEPTH];
  cdr_pkg::cdr_host_rsp_t push_entry;
  logic [1:0] wr_ptr_r;
  logic [1:0] rd_ptr_r;
  logic [2:0] count_r;
  logic push;
  logic pop;

  // deferred replies are our own, never queued from the bus
  assign push = I_HOST_VALID && O_HOST_READY && !is_defer;
  assign pop = I_HOST_POP && count_r != 3'h0;
  assign push_entry.dest = dest;
  assign push_entry.addr = addr;
  // branch trace data never captured
  assign push_entry.be_n = is_btm ? 8'hff : I_HOST_REQ.be_n;
  assign push_entry.code_a = code_a;

  // storage kept narrow: only the write slot changes
  always_ff @(posedge I_REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int i = 0; i < cdr_pkg::IOQ_DEPTH; i++) begin
        ioq_r[i] <= '0;
      end
    end else if (push) begin
      ioq_r[wr_ptr_r] <= push_entry;
    end
  end

  // pointers and occupancy, strictly first in first out
  always_ff @(posedge I_REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wr_ptr_r <= 2'h0;
      rd_ptr_r <= 2'h0;
      count_r <= 3'h0;
      O_HOST_READY <= 1'b0;
      O_HOST_RSP_VALID <= 1'b0;
      O_HOST_RSP <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + 2'(push);
      rd_ptr_r <= rd_ptr_r + 2'(pop);
      count_r <= count_r + 3'(push) - 3'(pop);
      O_HOST_READY <= (count_r + 3'(push) - 3'(pop)) < cdr_pkg::IOQ_DEPTH_C;
      O_HOST_RSP_VALID <= (count_r + 3'(push) - 3'(pop)) != 3'h0;
      O_HOST_RSP <= (count_r == 3'h0 || (pop && count_r == 3'h1)) ? push_entry
        : ioq_r[rd_ptr_r + 2'(pop)];
    end
  end

  // ****************************************
  // graphics port side
  // ****************************************
  logic blk_invalid;
  logic [19:0] last_page_r;
  logic frame_seen_r;

  cdr_gfx_split u_split (
    .clk(I_REF_CLK),
    .rst_n(rst_n_r),
    .cfg(I_CFG),
    .i_valid(I_GFX_VALID),
    .i_addr(I_GFX_ADDR),
    .i_bytes(I_GFX_BYTES),
    .i_write(I_GFX_WRITE),
    .o_busy(O_GFX_BUSY),
    .o_blk(O_GFX_BLK),
    .o_blk_valid(O_GFX_BLK_VALID),
    .o_invalid(blk_invalid)
  );

  // sticky flag: a new invalid block beats a clear in the same cycle
  always_ff @(posedge I_REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      O_INVALID_GRAPHICS_ACCESS_FLAG <= 1'b0;
    end else begin
      O_INVALID_GRAPHICS_ACCESS_FLAG <= blk_invalid
        || (O_INVALID_GRAPHICS_ACCESS_FLAG && !I_FLAG_CLEAR);
    end
  end

  // disconnect when a frame data phase enters a new 4 KB page
  always_ff @(posedge I_REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      last_page_r <= 20'h00000;
      frame_seen_r <= 1'b0;
      O_GFX_DISCONNECT <= 1'b0;
    end else begin
      frame_seen_r <= I_GFX_FRAME_ADDR_VALID;
      if (I_GFX_FRAME_ADDR_VALID) begin
        last_page_r <= I_GFX_FRAME_ADDR[31:cdr_pkg::PAGE_SHIFT];
      end
      O_GFX_DISCONNECT <= I_GFX_FRAME_ADDR_VALID && frame_seen_r
        && I_GFX_FRAME_ADDR[31:cdr_pkg::PAGE_SHIFT] != last_page_r;
    end
  end

endmodule

/* File: common/cdr_pkg.sv */
package cdr_pkg;

  // ****************************************
  // host request-phase codes
  // ****************************************
  localparam logic [4:0] REQA_DEFER_REPLY = 5'h00;
  localparam logic [4:0] REQA_INTA_SPEC = 5'h08;
  localparam logic [4:0] REQA_BRANCH_TRACE = 5'h09;
  localparam logic [4:0] REQA_IO_READ = 5'h10;
  localparam logic [4:0] REQA_IO_WRITE = 5'h11;
  localparam logic [4:0] REQA_MEM_RD_INV = 5'h02;
  localparam logic [4:0] REQA_MEM_CODE_RD = 5'h04;
  localparam logic [4:0] REQA_MEM_DATA_RD = 5'h06;
  localparam logic [4:0] REQA_MEM_WR_WB = 5'h05;
  localparam logic [4:0] REQA_MEM_WR_RETRY = 5'h07;
  localparam logic [4:0] REQB_ZERO = 5'h00;

  // ****************************************
  // legacy ranges
  // ****************************************
  localparam logic [31:0] VGA_MEM_LO = 32'h000a0000;
  localparam logic [31:0] VGA_MEM_HI = 32'h000bffff;
  localparam logic [31:0] MONO_MEM_LO = 32'h000b0000;
  localparam logic [31:0] MONO_MEM_HI = 32'h000b7fff;
  localparam logic [31:0] SHADOW_LO = 32'h000a0000;
  localparam logic [31:0] SHADOW_HI = 32'h000fffff;
  localparam logic [9:0] VGA_IO_A_LO = 10'h3b0;
  localparam logic [9:0] VGA_IO_A_HI = 10'h3bb;
  localparam logic [9:0] VGA_IO_B_LO = 10'h3c0;
  localparam logic [9:0] VGA_IO_B_HI = 10'h3df;
  localparam logic [9:0] PORT_IO_LO = 10'h3bc;
  localparam logic [9:0] PORT_IO_HI = 10'h3bf;
  localparam logic [9:0] MONO_ONLY_IO = 10'h3bf;
  // own config-space io locations: address 0cf8h (4 bytes) and 0cfch (4 bytes)
  localparam logic [15:0] CFG_IO_LO = 16'h0cf8;
  localparam logic [15:0] CFG_IO_HI = 16'h0cff;

  // ****************************************
  // graphics port blocking and in-order queue depth
  // ****************************************
  localparam int BLOCK_BYTES = 32;
  localparam int BLOCK_SHIFT = 5;
  localparam int MAX_REQ_BYTES = 256;
  localparam logic [3:0] MAX_BLOCKS = 4'h8;
  localparam int PAGE_SHIFT = 12;
  localparam int IOQ_DEPTH = 4;
  localparam logic [2:0] IOQ_DEPTH_C = 3'h4;

  // ****************************************
  // carriers
  // ****************************************
  typedef enum logic [2:0] {
    DST_NONE = 3'b000,
    DST_DRAM = 3'b001,
    DST_HUB = 3'b010,
    DST_GFX = 3'b011,
    DST_INTERNAL = 3'b100,
    DST_DROP = 3'b101
  } cdr_dest_t;

  typedef struct packed {
    logic [4:0] code_a;
    logic [4:0] code_b;
    logic [31:0] addr;
    logic [7:0] be_n;
  } cdr_host_req_t;

  typedef struct packed {
    cdr_dest_t dest;
    logic [31:0] addr;
    logic [7:0] be_n;
    logic [4:0] code_a;
  } cdr_host_rsp_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] be_n;
    logic write;
    logic snoop;
    logic last;
  } cdr_gfx_blk_t;

  typedef struct packed {
    logic vga_route;
    logic mono_present;
    logic legacy_bus_en;
    logic [15:0] io_window_low;
    logic [15:0] io_window_high;
    logic [31:0] mem_window_low;
    logic [31:0] mem_window_high;
    logic [31:0] prefetch_window_low;
    logic [31:0] prefetch_window_high;
    logic [31:0] dram_top;
    logic [31:0] aperture_base;
    logic [31:0] aperture_limit;
    logic [31:0] smm_low;
    logic [31:0] smm_high;
  } cdr_cfg_t;

endpackage

/* File: core/cdr_gfx_split.sv */
`timescale 1ns/1ps
// ****************************************
// graphics port request splitter
// ****************************************
module cdr_gfx_split (
  input wire logic clk,
  input wire logic rst_n,
  input wire cdr_pkg::cdr_cfg_t cfg,
  // request
  input wire logic i_valid,
  input wire logic [31:0] i_addr,
  input wire logic [8:0] i_bytes,
  input wire logic i_write,
  output logic o_busy,
  // blocks
  output cdr_pkg::cdr_gfx_blk_t o_blk,
  output logic o_blk_valid,
  output logic o_invalid
);
  logic [31:0] addr_r;
  logic [3:0] left_r;
  logic write_r;
  logic busy_r;
  logic [31:0] blk_addr;
  logic in_dram;
  logic in_aper;
  logic in_shadow;
  logic in_smm;
  logic valid_addr;
  logic [3:0] nblk;
  logic [9:0] span;

  // block count of a naturally aligned split; a misaligned 256-byte request needs nine
  assign span = {5'h00, i_addr[4:0]} + {1'b0, i_bytes} + 10'h01f;
  assign nblk = span[8:5];
  assign blk_addr = {addr_r[31:5], 5'h00};

  // validity: main dram minus legacy shadow and smm, or aperture
  assign in_dram = blk_addr < cfg.dram_top;
  assign in_shadow = blk_addr >= cdr_pkg::SHADOW_LO && blk_addr <= cdr_pkg::SHADOW_HI;
  assign in_smm = blk_addr >= cfg.smm_low && blk_addr <= cfg.smm_high;
  assign in_aper = blk_addr >= cfg.aperture_base && blk_addr <= cfg.aperture_limit;
  assign valid_addr = (in_dram && !in_shadow && !in_smm) || in_aper;

  // one block per cycle, in address order
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= 32'h00000000;
      left_r <= 4'h0;
      write_r <= 1'b0;
      busy_r <= 1'b0;
      o_blk <= '0;
      o_blk_valid <= 1'b0;
      o_invalid <= 1'b0;
    end else begin
      o_blk_valid <= busy_r;
      o_invalid <= busy_r && !valid_addr;
      o_blk.addr <= valid_addr ? blk_addr : 32'h00000000;
      o_blk.be_n <= (write_r && !valid_addr) ? 8'hff : 8'h00;
      o_blk.write <= write_r;
      o_blk.snoop <= 1'b0;
      o_blk.last <= busy_r && left_r == 4'h1;
      if (busy_r) begin
        addr_r <= addr_r + 32'h00000020;
        left_r <= left_r - 4'h1;
        busy_r <= left_r != 4'h1;
      end else if (i_valid && i_bytes != 9'h000) begin
        addr_r <= i_addr;
        left_r <= nblk;
        write_r <= i_write;
        busy_r <= 1'b1;
      end
    end
  end

  assign o_busy = busy_r;
endmodule

/* File: testbench/cdr_router_sva.sv */
`timescale 1ns/1ps
// ****
// router port checker
// ****
module cdr_chk (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  // host side
  input wire logic I_HOST_VALID,
  input wire cdr_pkg::cdr_host_req_t I_HOST_REQ,
  input wire logic I_HOST_POP,
  input wire logic O_HOST_READY,
  input wire logic O_HOST_RSP_VALID,
  input wire cdr_pkg::cdr_host_rsp_t O_HOST_RSP,
  // graphics side
  input wire logic I_GFX_VALID,
  input wire logic [8:0] I_GFX_BYTES,
  input wire logic I_GFX_FRAME_ADDR_VALID,
  input wire logic [31:0] I_GFX_FRAME_ADDR,
  input wire logic O_GFX_BUSY,
  input wire logic O_GFX_BLK_VALID,
  input wire cdr_pkg::cdr_gfx_blk_t O_GFX_BLK,
  input wire logic O_GFX_DISCONNECT,
  input wire logic O_INVALID_GRAPHICS_ACCESS_FLAG
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  wire logic [19:0] fpage = I_GFX_FRAME_ADDR[31:12];
  // occupancy from the port handshakes; deferred replies are never queued
  wire logic acc = I_HOST_VALID && O_HOST_READY && (I_HOST_REQ.code_a != cdr_pkg::REQA_DEFER_REPLY);
  wire logic rel = I_HOST_POP && O_HOST_RSP_VALID;
  assign cnt_nxt = cnt_r + 3'(acc) - 3'(rel);
  // queue depth tracker
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) cnt_r <= 3'h0;
    else cnt_r <= cnt_nxt;
  end
  property p_ioq_full;
    cnt_r == 3'h4 |-> !O_HOST_READY;
  endproperty
  a_ioq_full: assert property (p_ioq_full) else $error("ready high with four entries");
  property p_no_snoop;
    O_GFX_BLK_VALID |-> !O_GFX_BLK.snoop;
  endproperty
  a_no_snoop: assert property (p_no_snoop) else $error("graphics block snoops");
  property p_first_blk;
    I_GFX_VALID && !O_GFX_BUSY && (I_GFX_BYTES != 9'h000) |-> ##2 O_GFX_BLK_VALID;
  endproperty
  a_first_blk: assert property (p_first_blk) else $error("first block late");
  property p_flag_set;
    O_GFX_BLK_VALID && O_GFX_BLK.write && (O_GFX_BLK.be_n == 8'hff) |=> O_INVALID_GRAPHICS_ACCESS_FLAG;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("dropped write left flag clear");
  property p_drop_lanes;
    O_HOST_RSP_VALID && (O_HOST_RSP.dest == cdr_pkg::DST_DROP) |-> O_HOST_RSP.be_n == 8'hff;
  endproperty
  a_drop_lanes: assert property (p_drop_lanes) else $error("trace message keeps lanes");
  property p_wb_dram;
    O_HOST_RSP_VALID && (O_HOST_RSP.code_a == cdr_pkg::REQA_MEM_WR_WB) |-> O_HOST_RSP.dest == cdr_pkg::DST_DRAM;
  endproperty
  a_wb_dram: assert property (p_wb_dram) else $error("writeback not to dram");
  property p_no_defer;
    O_HOST_RSP_VALID |-> O_HOST_RSP.code_a != cdr_pkg::REQA_DEFER_REPLY;
  endproperty
  a_no_defer: assert property (p_no_defer) else $error("deferred reply queued");
  property p_disc;
    I_GFX_FRAME_ADDR_VALID && $past(I_GFX_FRAME_ADDR_VALID) && (fpage != $past(fpage)) |=> O_GFX_DISCONNECT;
  endproperty
  a_disc: assert property (p_disc) else $error("page crossing not disconnected");
endmodule

// every checker port carries the name of the router port it watches
bind cdr_router cdr_chk u_chk (.*);

/* File: testbench/cdr_host_agent.sv */
`timescale 1ns/1ps
// ****
// downstream consumer of routed host requests
// ****
module cdr_host_agent (
  // clock
  input wire logic clk,
  // queue head
  input wire logic i_rsp_valid,
  input wire logic i_hold,
  output logic o_pop
);
  int gap;
  // one-cycle pop, then a gap so a stale head is never retired twice
  initial begin
    o_pop = 1'b0;
    gap = 0;
    forever begin
      @(negedge clk);
      if (o_pop) begin
        o_pop = 1'b0;
        gap = 1;
      end else if (gap > 0) begin
        gap--;
      end else if (i_rsp_valid && !i_hold && $urandom_range(2) != 0) begin
        o_pop = 1'b1;
      end
    end
  end
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
// ****
// router testbench
// ****
module tb_top;
  typedef struct packed {cdr_pkg::cdr_dest_t d; logic [4:0] c;} cdr_hexp_t;
  typedef struct packed {logic [31:0] a; logic off; logic w; logic l;} cdr_gexp_t;
  logic clk = 1'b0;
  logic rst_n, hv, pop, hold, rdy, rv, gv, gw, fv, fclr, busy, bv, disc, flag;
  logic [31:0] ga, fa;
  logic [8:0] gb;
  cdr_pkg::cdr_cfg_t cfg;
  cdr_pkg::cdr_host_req_t hreq;
  cdr_pkg::cdr_host_rsp_t rsp;
  cdr_pkg::cdr_gfx_blk_t blk;
  cdr_hexp_t hq[$];
  cdr_gexp_t gq[$];
  cdr_hexp_t he;
  cdr_gexp_t ge;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int ndisc = 0;

  // 200 MHz reference
  always #2.5 clk = ~clk;

  cdr_router u_dut (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_CFG(cfg), .I_HOST_VALID(hv), .I_HOST_REQ(hreq),
    .I_HOST_POP(pop), .O_HOST_READY(rdy), .O_HOST_RSP_VALID(rv), .O_HOST_RSP(rsp), .I_GFX_VALID(gv),
    .I_GFX_ADDR(ga), .I_GFX_BYTES(gb), .I_GFX_WRITE(gw), .I_GFX_FRAME_ADDR_VALID(fv), .I_GFX_FRAME_ADDR(fa),
    .I_FLAG_CLEAR(fclr), .O_GFX_BUSY(busy), .O_GFX_BLK_VALID(bv), .O_GFX_BLK(blk), .O_GFX_DISCONNECT(disc),
    .O_INVALID_GRAPHICS_ACCESS_FLAG(flag));
  cdr_host_agent u_agent (.clk(clk), .i_rsp_valid(rv), .i_hold(hold), .o_pop(pop));

  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic summarize();
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // valid main memory: dram minus legacy shadow and system management, or aperture
  function automatic bit ok(input logic [31:0] a);
    return (a < cfg.dram_top && !(a >= cdr_pkg::SHADOW_LO && a <= cdr_pkg::SHADOW_HI) &&
      !(a >= cfg.smm_low && a <= cfg.smm_high)) || (a >= cfg.aperture_base && a <= cfg.aperture_limit);
  endfunction

  // request held until ready is seen high at an edge
  task automatic h(input logic [4:0] ca, input logic [31:0] ad, input logic [7:0] be, input cdr_pkg::cdr_dest_t d);
    int k;
    k = 0;
    @(negedge clk);
    hv = 1'b1;
    hreq = {ca, 5'h00, ad, be};
    @(posedge clk);
    while (!rdy && k < 100) begin
      k++;
      @(posedge clk);
    end
    if (ca != cdr_pkg::REQA_DEFER_REPLY) hq.push_back({d, ca});
  endtask

  // drain, then change the static routing setup
  task automatic m(input logic vg, input logic mo, input logic lg, input logic [15:0] lo, input logic [15:0] hi);
    int k;
    k = 0;
    @(negedge clk);
    hv = 1'b0;
    while ((rv || hq.size() != 0) && k < 200) begin
      k++;
      @(negedge clk);
    end
    {cfg.vga_route, cfg.mono_present, cfg.legacy_bus_en} = {vg, mo && vg, lg};
    {cfg.io_window_low, cfg.io_window_high} = {lo, hi};
  endtask

  // queued graphics request; expected blocks noted up front
  task automatic g(input logic [31:0] a, input logic [8:0] n, input logic w);
    int nb;
    int k;
    logic [31:0] ba;
    nb = (int'(a[4:0]) + int'(n) + 31) / 32;
    for (int i = 0; i < nb; i++) begin
      ba = {a[31:5], 5'h00} + 32'(32 * i);
      gq.push_back({ok(ba) ? ba : 32'h0, w && !ok(ba), w, i == nb - 1});
    end
    @(negedge clk);
    {gv, ga, gb, gw} = {1'b1, a, n, w};
    k = 0;
    @(posedge clk);
    while (busy && k < 100) begin
      k++;
      @(posedge clk);
    end
    @(negedge clk);
    gv = 1'b0;
    while (busy && k < 300) begin
      k++;
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask

  // frame-based burst of n words
  task automatic f(input logic [31:0] a, input int n, input int ex);
    ndisc = 0;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      fv = 1'b1;
      fa = a + 32'(4 * i);
    end
    @(negedge clk);
    fv = 1'b0;
    repeat (3) @(posedge clk);
    cmp("disconnects", 32'(ex), 32'(ndisc));
  endtask

  task automatic clr();
    @(negedge clk);
    fclr = 1'b1;
    @(negedge clk);
    fclr = 1'b0;
    @(negedge clk);
    cmp("flag_clear", 0, flag);
  endtask

  // host results: the retired head must match the oldest request taken
  always @(posedge clk) begin
    if (pop && rv) begin
      if (hq.size() == 0) cmp("host_extra", 0, 1);
      else begin
        he = hq.pop_front();
        cmp("host_dest", 32'(he.d), 32'(rsp.dest));
        cmp("host_code", 32'(he.c), 32'(rsp.code_a));
        if (he.d == cdr_pkg::DST_DROP) cmp("host_lanes", 32'hff, 32'(rsp.be_n));
      end
    end
  end

  // graphics blocks in order
  always @(posedge clk) begin
    if (bv) begin
      if (gq.size() == 0) cmp("blk_extra", 0, 1);
      else begin
        ge = gq.pop_front();
        cmp("blk_addr", ge.a, blk.addr);
        cmp("blk_bits", {29'h0, 1'b0, ge.l, ge.w}, {29'h0, blk.snoop, blk.last, blk.write});
        if (ge.off) cmp("blk_lanes", 32'hff, 32'(blk.be_n));
      end
    end
  end

  // disconnect pulses and hang limit
  always @(posedge clk) begin
    cyc++;
    if (disc) ndisc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    cfg = '0;
    {cfg.dram_top, cfg.aperture_base, cfg.aperture_limit} = {32'h01000000, 32'h80000000, 32'h8fffffff};
    {cfg.smm_low, cfg.smm_high, cfg.mem_window_low} = {32'hfff00000, 32'hffffffff, 32'h40000000};
    {cfg.mem_window_high, cfg.prefetch_window_low, cfg.prefetch_window_high} = {32'h4fffffff, 32'h50000000, 32'h5fffffff};
    {rst_n, hv, hold, gv, gw, fv, fclr} = 7'h00;
    {hreq, ga, gb, fa} = '0;
    void'($urandom(58));
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    m(1'b0, 1'b0, 1'b0, 16'h0300, 16'h03ff);
    h(cdr_pkg::REQA_MEM_DATA_RD, 32'h00001000, 8'h00, cdr_pkg::DST_DRAM);
    h(cdr_pkg::REQA_MEM_RD_INV, 32'h20000000, 8'h00, cdr_pkg::DST_HUB);
    h(cdr_pkg::REQA_MEM_CODE_RD, 32'h00002000, 8'h00, cdr_pkg::DST_DRAM);
    h(cdr_pkg::REQA_MEM_WR_WB, 32'h20000000, 8'h00, cdr_pkg::DST_DRAM);
    h(cdr_pkg::REQA_MEM_WR_RETRY, 32'h20000000, 8'h00, cdr_pkg::DST_HUB);
    h(cdr_pkg::REQA_MEM_WR_RETRY, 32'h00003000, 8'h00, cdr_pkg::DST_DRAM);
    h(cdr_pkg::REQA_INTA_SPEC, 32'h0, 8'h00, cdr_pkg::DST_HUB);
    h(cdr_pkg::REQA_DEFER_REPLY, 32'h0, 8'h00, cdr_pkg::DST_NONE);
    h(cdr_pkg::REQA_BRANCH_TRACE, 32'h0, 8'h00, cdr_pkg::DST_DROP);
    h(5'h01, 32'h00001000, 8'h00, cdr_pkg::DST_NONE);
    h(5'h18, 32'h00001000, 8'h00, cdr_pkg::DST_NONE);
    h(cdr_pkg::REQA_IO_READ, 32'h00000cf8, 8'hf0, cdr_pkg::DST_INTERNAL);
    h(cdr_pkg::REQA_IO_WRITE, 32'h00000100, 8'hf0, cdr_pkg::DST_HUB);
    h(cdr_pkg::REQA_MEM_DATA_RD, 32'h000a0000, 8'h00, cdr_pkg::DST_HUB);
    h(cdr_pkg::REQA_IO_READ, 32'h000003c0, 8'hfe, cdr_pkg::DST_GFX);
    h(cdr_pkg::REQA_IO_WRITE, 32'h000003bc, 8'hfe, cdr_pkg::DST_GFX);
    m(1'b0, 1'b0, 1'b1, 16'h0300, 16'h03ff);
    h(cdr_pkg::REQA_IO_READ, 32'h000003bc, 8'hfe, cdr_pkg::DST_HUB);
    m(1'b0, 1'b0, 1'b0, 16'h1000, 16'h1fff);
    h(cdr_pkg::REQA_IO_READ, 32'h000003c0, 8'hfe, cdr_pkg::DST_HUB);
    m(1'b1, 1'b0, 1'b1, 16'h1000, 16'h1fff);
    h(cdr_pkg::REQA_MEM_DATA_RD, 32'h000a0000, 8'h00, cdr_pkg::DST_GFX);
    h(cdr_pkg::REQA_MEM_WR_RETRY, 32'h000bfff8, 8'h00, cdr_pkg::DST_GFX);
    h(cdr_pkg::REQA_IO_WRITE, 32'h000007df, 8'hfe, cdr_pkg::DST_GFX);
    h(cdr_pkg::REQA_IO_READ, 32'h000003bb, 8'hfe, cdr_pkg::DST_GFX);
    h(cdr_pkg::REQA_IO_READ, 32'h000003e0, 8'hfe, cdr_pkg::DST_HUB);
    h(cdr_pkg::REQA_IO_READ, 32'h000003bd, 8'hfe, cdr_pkg::DST_HUB);
    h(cdr_pkg::REQA_IO_READ, 32'h000003b4, 8'hfe, cdr_pkg::DST_GFX);
    h(cdr_pkg::REQA_IO_READ, 32'h000007bf, 8'hfe, cdr_pkg::DST_HUB);
    m(1'b1, 1'b1, 1'b0, 16'h1000, 16'h1fff);
    h(cdr_pkg::REQA_IO_READ, 32'h000003b2, 8'hf0, cdr_pkg::DST_HUB);
    h(cdr_pkg::REQA_IO_READ, 32'h000003b0, 8'hfe, cdr_pkg::DST_GFX);
    h(cdr_pkg::REQA_MEM_DATA_RD, 32'h000b0000, 8'h00, cdr_pkg::DST_HUB);
    h(cdr_pkg::REQA_MEM_DATA_RD, 32'h000b8000, 8'h00, cdr_pkg::DST_GFX);
    m(1'b1, 1'b1, 1'b0, 16'h1000, 16'h1fff);
    hold = 1'b1;
    h(cdr_pkg::REQA_IO_READ, 32'h00000cfc, 8'hf0, cdr_pkg::DST_INTERNAL);
    h(cdr_pkg::REQA_MEM_DATA_RD, 32'h00004000, 8'h00, cdr_pkg::DST_DRAM);
    h(cdr_pkg::REQA_INTA_SPEC, 32'h0, 8'h00, cdr_pkg::DST_HUB);
    h(cdr_pkg::REQA_BRANCH_TRACE, 32'h0, 8'h00, cdr_pkg::DST_DROP);
    @(negedge clk);
    hv = 1'b0;
    repeat (2) @(negedge clk);
    cmp("ready_full", 0, rdy);
    hold = 1'b0;
    m(1'b0, 1'b0, 1'b0, 16'h1000, 16'h1fff);
    g(32'h00001000, 9'h100, 1'b1);
    g(32'h00001010, 9'h028, 1'b0);
    g(32'h80000000, 9'h040, 1'b0);
    repeat (6) g(32'h00100000 + $urandom_range(32'h00e00000), 9'($urandom_range(256, 1)), 1'($urandom_range(1)));
    cmp("flag_valid", 0, flag);
    g(32'h00ffffe0, 9'h040, 1'b1);
    cmp("flag_wr", 1, flag);
    clr();
    g(32'h20000004, 9'h001, 1'b0);
    cmp("flag_rd", 1, flag);
    clr();
    f(32'h00000ff0, 8, 1);
    f(32'h00002000, 8, 0);
    f(32'h00001ff8, 4, 1);
    repeat (20) @(negedge clk);
    cmp("host_left", 0, 32'(hq.size()));
    cmp("blk_left", 0, 32'(gq.size()));
    summarize();
  end
endmodule
